/* File: rtl/tpc_device.sv */
// Device end: control byte decode, power, pen gating, conversion framing
// Contract
// - Differential mode only for X, Y, pressure
// - Reference enable separate from converter enable
// - No wake-up delay after power-down
// - Reference power latched on busy rise; code latches it on the clock rise before busy rises
// - Bits 00: auto power-down, pen enabled
// - Bits 01: reference off, converter on, pen off; code powers the converter only while chip select is low
// - Bits 10: reference on, converter off, pen on
// - Bits 11: all on, pen disabled; code powers the converter only while chip select is low
// - Powered down: Y driver on, alert follows touch; code samples touch only on link clock rises
// - Position cycles disconnect pen pull-up
// - Position cycles hold alert low
// - Other measurement cycles hold alert high
// - Lower bit set keeps pen detect off
// - Lower bit clear re-enables at conversion end
// - Host masks alert while sending control
// - Next control byte overlaps result shifting
// - Host completes conversion within 1.6ms
// - Stays powered while clock pauses mid-conversion
// - Supports 15 clocks per conversion
// - Ignore input until start bit; field order
// - Three acquire clocks, twelve convert, MSB first
// - Chip select high aborts, keeps reference
// - New byte every 15th or 11th clock
`timescale 1ns/100ps
`default_nettype none
module tpc_device
    import tpc_pkg::*;
(
    // Link side
    tpc_link_if.dev          link,
    // Clock enable and reset
    input  wire logic        CE,
    input  wire logic        RST,
    // Analog stand-ins
    input  wire logic        TOUCH_SENSE,
    input  wire logic [11:0] SAMPLE_CODE,
    // Power and switch state
    output logic             REF_ON,
    output logic             ADC_ON,
    output logic             Y_DRIVER_ON,
    output logic             PULLUP_ON,
    output logic [2:0]       CHANNEL,
    output logic             REF_SINGLE
);
    tpc_state_t  state_q;
    logic [4:0]  cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  ctrl_q;
    logic [11:0] result_q;
    logic        ref_q;
    logic        pen_en_q;
    logic        busy_q;
    logic        dout_q;
    logic [4:0]  end_cnt;
    logic [7:0]  shift_d;
    logic        rst_any;
    logic        touch_s1_q;
    logic        touch_s2_q;

    // Chip select acts as reset of framing and output shifting
    assign rst_any = RST | link.cs_n;
    assign shift_d = {shift_q[6:0], link.din};
    assign end_cnt = ctrl_q[POS_MODE] ? CNT_END_8 : CNT_END_12;

    // Framing: hunt start bit, then count clocks
    always_ff @(posedge link.serial_clock_in) begin
        if (rst_any) begin
            state_q <= TPC_IDLE;
            cnt_q   <= 5'h00;
            shift_q <= 8'h00;
        end else if (CE) begin
            shift_q <= shift_d;
            case (state_q)
                TPC_IDLE: begin
                    if (shift_d[7]) begin
                        state_q <= TPC_ACQ;
                        cnt_q   <= CNT_CONV_START;
                    end else if (shift_q == 8'h00 && !link.din) begin
                        cnt_q <= 5'h00;
                    end
                end
                TPC_ACQ: begin
                    state_q <= TPC_CONV;
                    cnt_q   <= cnt_q + 5'h01;
                end
                TPC_CONV: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == end_cnt) begin
                        state_q <= TPC_TAIL;
                    end
                end
                TPC_TAIL: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (shift_d[7] && cnt_q >= (ctrl_q[POS_MODE] ? CNT_NEXT_8 : CNT_NEXT_12)) begin
                        state_q <= TPC_ACQ;
                        cnt_q   <= CNT_CONV_START;
                    end else if (cnt_q == CNT_END_12 + 5'h03) begin
                        state_q <= TPC_IDLE;
                    end
                end
                default: state_q <= TPC_IDLE;
            endcase
        end
    end

    // Control byte capture and reference latch on the clock rise that completes the byte, before busy rises
    always_ff @(posedge link.serial_clock_in) begin
        if (RST) begin
            ctrl_q <= 8'h00;
            ref_q  <= 1'b0;
        end else if (CE && !link.cs_n && (state_q != TPC_ACQ) && (state_q != TPC_CONV) && shift_d[7]
                     && (state_q == TPC_IDLE || cnt_q >= (ctrl_q[POS_MODE] ? CNT_NEXT_8 : CNT_NEXT_12))) begin
            ctrl_q <= shift_d;
            ref_q  <= shift_d[POS_REFPWR];
        end
    end

    // Busy rises on falling edge after control byte; data shifted on falling edges
    always_ff @(negedge link.serial_clock_in) begin
        if (rst_any) begin
            busy_q   <= 1'b0;
            dout_q   <= 1'b0;
            result_q <= 12'h000;
        end else if (CE) begin
            busy_q <= (state_q == TPC_ACQ);
            if (state_q == TPC_ACQ) begin
                result_q <= ctrl_q[POS_MODE] ? {SAMPLE_CODE[11:4], 4'h0} : SAMPLE_CODE;
                dout_q   <= 1'b0;
            end else if (state_q == TPC_CONV) begin
                dout_q   <= result_q[11];
                result_q <= {result_q[10:0], 1'b0};
            end else begin
                dout_q <= 1'b0;
            end
        end
    end

    // Pen detect enable, re-armed at end of conversion
    always_ff @(negedge link.serial_clock_in) begin
        if (RST) begin
            pen_en_q <= 1'b1;
        end else if (CE && !link.cs_n) begin
            if (state_q == TPC_ACQ) begin
                pen_en_q <= 1'b0;
            end else if (state_q == TPC_TAIL && !ctrl_q[POS_PDLOW]) begin
                pen_en_q <= 1'b1;
            end
        end
    end

    // Touch input synchroniser
    always_ff @(posedge link.serial_clock_in) begin
        if (RST) begin
            touch_s1_q <= 1'b0;
            touch_s2_q <= 1'b0;
        end else begin
            touch_s1_q <= TOUCH_SENSE;
            touch_s2_q <= touch_s1_q;
        end
    end

    logic active;
    logic touch_ch;
    assign active   = !link.cs_n && (state_q == TPC_ACQ || state_q == TPC_CONV);
    assign touch_ch = tpc_is_touch_ch(ctrl_q[POS_CH_HI:POS_CH_LO]) && !ctrl_q[POS_REFSEL];

    // Power and alert outputs
    always_comb begin
        REF_ON      = ref_q;
        ADC_ON      = active || (!link.cs_n && ctrl_q[POS_PDLOW]);
        Y_DRIVER_ON = !active && pen_en_q && !ctrl_q[POS_PDLOW];
        PULLUP_ON   = !(active && touch_ch);
        CHANNEL     = ctrl_q[POS_CH_HI:POS_CH_LO];
        REF_SINGLE  = ctrl_q[POS_REFSEL];
    end

    always_comb begin
        if (active) begin
            link.touch_alert_n = !touch_ch;
        end else if (pen_en_q && !ctrl_q[POS_PDLOW]) begin
            link.touch_alert_n = !touch_s2_q;
        end else begin
            link.touch_alert_n = 1'b1;
        end
    end

    assign link.busy = busy_q && !link.cs_n;
    assign link.dout = dout_q && !link.cs_n;
endmodule
`default_nettype wire

/* File: rtl/tpc_host.sv */
// Host end: 24-clock non-overlapped control byte master with divided clock
`timescale 1ns/100ps
`default_nettype none
module tpc_host
    import tpc_pkg::*;
(
    // Clock, enable, reset
    input  wire logic        CLK_SYS,
    input  wire logic        CE,
    input  wire logic        RST,
    // User request
    input  wire logic        REQ_VALID,
    input  wire logic [7:0]  REQ_CTRL,
    output logic             REQ_READY,
    // Result
    output logic             RES_VALID,
    output logic [11:0]      RES_DATA,
    output logic             ALERT_MASKED,
    // Link side
    tpc_link_if.host         link
);
    logic [7:0]  tx_q;
    logic [11:0] rx_q;
    logic [4:0]  bit_q;
    logic        sclk_q;
    logic        div_q;
    logic        run_q;
    logic        cs_q;
    logic        dout_s1_q;
    logic        dout_s2_q;
    logic        alert_s1_q;
    logic        alert_s2_q;

    // Divided serial clock and frame sequencing
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sclk_q    <= 1'b0;
            div_q     <= 1'b0;
            run_q     <= 1'b0;
            cs_q      <= 1'b1;
            bit_q     <= 5'h00;
            tx_q      <= 8'h00;
            rx_q      <= 12'h000;
            REQ_READY <= 1'b0;
            RES_VALID <= 1'b0;
            RES_DATA  <= 12'h000;
        end else if (CE) begin
            RES_VALID <= 1'b0;
            REQ_READY <= !run_q && !(REQ_VALID && REQ_READY);
            if (!run_q) begin
                if (REQ_VALID && REQ_READY) begin
                    tx_q      <= REQ_CTRL | 8'h80;
                    run_q     <= 1'b1;
                    cs_q      <= 1'b0;
                    bit_q     <= 5'h00;
                    REQ_READY <= 1'b0;
                end
            end else begin
                div_q <= ~div_q;
                if (div_q) begin
                    sclk_q <= ~sclk_q;
                    if (sclk_q) begin
                        // Result bits sampled late in the high phase, past the synchroniser lag
                        if (bit_q > CNT_CONV_START && bit_q <= CNT_END_12) begin
                            rx_q <= {rx_q[10:0], dout_s2_q};
                        end
                        tx_q  <= {tx_q[6:0], 1'b0};
                        bit_q <= bit_q + 5'h01;
                        if (bit_q == 5'h17) begin // full 24-clock frame
                            run_q     <= 1'b0;
                            cs_q      <= 1'b1;
                            RES_VALID <= 1'b1;
                            RES_DATA  <= rx_q;
                        end
                    end
                end
            end
        end
    end

    // Input synchronisers
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            dout_s1_q  <= 1'b0;
            dout_s2_q  <= 1'b0;
            alert_s1_q <= 1'b1;
            alert_s2_q <= 1'b1;
            ALERT_MASKED <= 1'b0;
        end else begin
            dout_s1_q  <= link.dout;
            dout_s2_q  <= dout_s1_q;
            alert_s1_q <= link.touch_alert_n;
            alert_s2_q <= alert_s1_q;
            ALERT_MASKED <= !alert_s2_q && !run_q;
        end
    end

    assign link.serial_clock_in = sclk_q;
    assign link.cs_n            = cs_q;
    assign link.din             = tx_q[7];
endmodule
`default_nettype wire

/* File: rtl/tpc_link_if.sv */
// Serial link between touch converter control and its host
`timescale 1ns/100ps
`default_nettype none
interface tpc_link_if;
    logic serial_clock_in;
    logic cs_n;
    logic din;
    logic dout;
    logic busy;
    logic touch_alert_n;
    modport dev  (input serial_clock_in, cs_n, din, output dout, busy, touch_alert_n);
    modport host (output serial_clock_in, cs_n, din, input dout, busy, touch_alert_n);
endinterface
`default_nettype wire

/* File: rtl/tpc_pkg.sv */
// Shared constants and types for the touch converter control link
package tpc_pkg;
    localparam int unsigned CTRL_BITS      = 8;
    localparam int unsigned RES_BITS       = 12;
    localparam int unsigned ACQ_CLKS       = 3;
    localparam int unsigned CNT_W          = 5;
    localparam logic [4:0]  CNT_CONV_START = 5'h08;
    localparam logic [4:0]  CNT_END_12     = 5'h14;
    localparam logic [4:0]  CNT_END_8      = 5'h10;
    localparam logic [4:0]  CNT_NEXT_12    = 5'h0f;
    localparam logic [4:0]  CNT_NEXT_8     = 5'h0b;
    localparam int unsigned POS_START      = 7;
    localparam int unsigned POS_CH_HI      = 6;
    localparam int unsigned POS_CH_LO      = 4;
    localparam int unsigned POS_MODE       = 3;
    localparam int unsigned POS_REFSEL     = 2;
    localparam int unsigned POS_REFPWR     = 1;
    localparam int unsigned POS_PDLOW      = 0;
    localparam logic [2:0]  CH_Y           = 3'h1;
    localparam logic [2:0]  CH_Z1          = 3'h3;
    localparam logic [2:0]  CH_Z2          = 3'h4;
    localparam logic [2:0]  CH_X           = 3'h5;
    localparam logic [1:0]  PWR_RESET      = 2'h0;
    localparam int unsigned HOST_DIV       = 2;
    localparam int unsigned HOLD_LIMIT_US  = 1600;
    localparam int unsigned CLK_SYS_MHZ    = 100;
    localparam int unsigned HOLD_LIMIT_CYC = HOLD_LIMIT_US * CLK_SYS_MHZ;

    typedef enum logic [1:0] {
        TPC_IDLE = 2'b00,
        TPC_ACQ  = 2'b01,
        TPC_CONV = 2'b11,
        TPC_TAIL = 2'b10
    } tpc_state_t;

    function automatic logic tpc_is_touch_ch(input logic [2:0] ch);
        tpc_is_touch_ch = (ch == CH_X) || (ch == CH_Y) || (ch == CH_Z1) || (ch == CH_Z2);
    endfunction
endpackage

/* File: tb/touch_adc_power_pen_control_tb_top.sv */
// Bench joining host and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module touch_adc_power_pen_control_tb_top;
    import tpc_pkg::*;
    logic        clk_sys, rst, req_valid, touch_sense, req_ready, res_valid, alert_masked;
    logic        ref_on, adc_on, y_drv, pullup_on, ref_single;
    logic [7:0]  req_ctrl;
    logic [11:0] sample_code, res_data;
    logic [2:0]  channel;
    int          err_total, n_checks;

    tpc_link_if link ();
    tpc_host tpc_host_i (.CLK_SYS(clk_sys), .CE(1'b1), .RST(rst), .REQ_VALID(req_valid), .REQ_CTRL(req_ctrl),
        .REQ_READY(req_ready), .RES_VALID(res_valid), .RES_DATA(res_data), .ALERT_MASKED(alert_masked), .link(link));
    tpc_device tpc_device_i (.link(link), .CE(1'b1), .RST(rst), .TOUCH_SENSE(touch_sense), .SAMPLE_CODE(sample_code),
        .REF_ON(ref_on), .ADC_ON(adc_on), .Y_DRIVER_ON(y_drv), .PULLUP_ON(pullup_on), .CHANNEL(channel),
        .REF_SINGLE(ref_single));
    tpc_link_properties tpc_link_properties_i (.CLK_SYS(clk_sys), .RST(rst), .serial_clock_in(link.serial_clock_in),
        .cs_n(link.cs_n), .din(link.din), .busy(link.busy));

    task automatic cmp(input logic good, input string m);
        n_checks++;
        if (good !== 1'b1) begin
            err_total++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    // One whole frame with checks drawn from the control byte
    task automatic conv(input logic [7:0] c, input logic [11:0] code);
        logic [11:0] exp;
        logic        hit;
        logic        pos;
        exp = c[3] ? {code[11:4], 4'h0} : code;
        pos = c[6:4] inside {CH_X, CH_Y, CH_Z1, CH_Z2};
        @(posedge clk_sys);
        sample_code <= code;
        req_ctrl <= c;
        req_valid <= 1'b1;
        hit = 1'b0;
        for (int i = 0; i < 50 && !hit; i++) begin
            @(negedge clk_sys);
            hit = (req_ready === 1'b1);
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        hit = 1'b0;
        for (int i = 0; i < 200 && !hit; i++) begin
            @(negedge clk_sys);
            hit = (link.busy === 1'b1);
        end
        cmp(hit && adc_on === 1'b1, "converter off at start");
        cmp(channel === c[6:4] && ref_single === c[2], "fields misplaced");
        cmp(link.touch_alert_n === !pos, "alert level in measurement");
        if (pos) cmp(pullup_on === 1'b0, "pull-up left on");
        hit = 1'b0;
        for (int i = 0; i < 300 && !hit; i++) begin
            @(negedge clk_sys);
            hit = (res_valid === 1'b1);
        end
        cmp(hit && res_data === exp, "result mismatch");
        repeat (4) @(negedge clk_sys);
        cmp(ref_on === c[1], "reference state");
        if (!c[0]) cmp(adc_on === 1'b0 && y_drv === 1'b1, "not powered down");
    endtask

    task automatic t_position();
        touch_sense <= 1'b1;
        conv(8'hd0, 12'ha5c);
        repeat (4) @(negedge clk_sys);
        cmp(alert_masked === 1'b1, "touch not seen while idle");
        $display("test position done");
    endtask

    task automatic t_aux_ref_on();
        conv(8'hae, 12'h3c7);
        $display("test aux_ref_on done");
    endtask

    task automatic t_ref_off();
        conv(8'he5, 12'h81f);
        repeat (4) @(negedge clk_sys);
        cmp(alert_masked === 1'b0, "pen detect left on");
        $display("test ref_off done");
    endtask

    task automatic t_full_power();
        conv(8'hd3, 12'hfff);
        conv(8'h93, 12'h001);
        conv(8'h10, 12'h6b2);
        $display("test full_power done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #60000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        rst = 1'b1;
        req_valid = 1'b0;
        req_ctrl = 8'h00;
        touch_sense = 1'b0;
        sample_code = 12'h000;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_position();
        t_aux_ref_on();
        t_ref_off();
        t_full_power();
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: tb/tpc_link_properties.sv */
// Link protocol assertions for the touch converter control link
`timescale 1ns/100ps
`default_nettype none
module tpc_link_properties (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Link signals
    input wire logic serial_clock_in,
    input wire logic cs_n,
    input wire logic din,
    input wire logic busy
);
    logic       sclk_q;
    logic [5:0] rise_cnt_q;

    // Link clock rises within the current frame
    always_ff @(posedge CLK_SYS) sclk_q <= serial_clock_in;
    always_ff @(posedge CLK_SYS) begin
        if (RST || cs_n) begin
            rise_cnt_q <= 6'h00;
        end else if (serial_clock_in && !sclk_q) begin
            rise_cnt_q <= rise_cnt_q + 6'h01;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    idle_clock_a: assert property (cs_n && $past(cs_n) |-> $stable(serial_clock_in))
        else $error("link clock moved outside a frame");
    clock_divider_a: assert property ($rose(serial_clock_in) && !cs_n |=> serial_clock_in ##1 !serial_clock_in)
        else $error("link clock high phase not two cycles");
    din_stable_a: assert property (!cs_n && serial_clock_in && $past(serial_clock_in) |-> $stable(din))
        else $error("data in changed while link clock high");
    frame_open_a: assert property ($fell(cs_n) |-> !serial_clock_in)
        else $error("frame opened with link clock high");
    start_bit_a: assert property ($fell(cs_n) |-> din)
        else $error("first control bit not high");
    frame_length_a: assert property ($rose(cs_n) |-> rise_cnt_q == 6'h18)
        else $error("frame not 24 link clocks");
    busy_start_a: assert property ($rose(busy) |-> rise_cnt_q inside {[6'h05:6'h09]})
        else $error("busy rose at wrong clock");
    busy_end_a: assert property ($rose(busy) |-> ##[1:100] !busy)
        else $error("busy never fell");
endmodule
`default_nettype wire
